//--- cscr_core_regs.sv
// Architectural registers of the core: sixteen general registers with
// stack aliasing, status word, PC, vector base, return pointer, multiply
// and divide registers, interrupt entry sequencing, APB register access.
// Assumes the core sequencer drives the instruction event pulses and
// that all inputs are synchronous to core_clk.
//
// Contract
// - Reset loads system stack (R15) with zero; R0..R14 are undefined.
// - Reserved status bits read zero; writes to them are ignored.
// - Flag byte: SV,S,I at bits 6..4, N,Z,V,C at 3..0; upper reset 0.
// - Divide flags at bits 10,9, trace enable at 8, cleared on reset.
// - Trace enable set gives a step trace trap; clear gives none.
// - Five-bit level mask at bits 20..16 resets to 01111.
// - PC holds the executing instruction address; reset loads zero.
// - Vector base gives vector table start; resets to 000FFC00.
// - Subroutine call copies PC into the return pointer.
// - Subroutine exit loads PC from return pointer.
// - Stack flag one maps R15 to user stack, also named directly.
// - Interrupt exit never touches the user stack pointer.
// - R13 accumulator, R14 frame pointer, R15 stack pointer.
// - Multiply and divide result registers are 32 bits, reset undefined.
// - 32x32 multiply takes five cycles, 16x16 takes three.
// - Interrupt entry takes six cycles, level masked, nestable.
// - Divide setup pre-updates both divide flags; replay gives same.
// - Status write enabling an active interrupt pre-updates, then enters.
`timescale 1ns/1ps
`include "cscr_params.svh"

module cscr_core_regs #(
  parameter int DATA_W = 32,
  parameter int GPR_NUM = 16
) (
  // Clock, reset and enable
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Core general register ports
  input  wire logic [3:0]        gprRdIdx,
  output logic      [DATA_W-1:0] gprRdData,
  input  wire logic              gprWrEn,
  input  wire logic [3:0]        gprWrIdx,
  input  wire logic [DATA_W-1:0] gprWrData,
  // Instruction events
  input  wire logic              instrDone,
  input  wire logic [DATA_W-1:0] nextPc,
  input  wire logic              callInstr,
  input  wire logic [DATA_W-1:0] callTarget,
  input  wire logic              retInstr,
  input  wire logic              retiInstr,
  input  wire logic [DATA_W-1:0] retiPc,
  input  wire logic [DATA_W-1:0] retiPs,
  input  wire logic              divSetup,
  input  wire logic [1:0]        divFlags,
  input  wire logic              psWrEn,
  input  wire logic [DATA_W-1:0] psWrData,
  // Interrupt request
  input  wire logic              irqReq,
  input  wire logic [4:0]        irqLevel,
  input  wire logic [7:0]        irqVector,
  // Status outputs
  output logic      [DATA_W-1:0] pcOut,
  output logic      [DATA_W-1:0] psOut,
  output logic                   eitEntry,
  output logic      [DATA_W-1:0] eitSavedPc,
  output logic      [DATA_W-1:0] eitSavedPs,
  output logic                   traceTrap,
  output logic                   mulBusy
);

  ////////////////////////////////////////////////////////////////////////
  logic [DATA_W-1:0] gprMem [0:GPR_NUM-2];
  logic [DATA_W-1:0] pcReg;
  logic [DATA_W-1:0] psReg;
  logic [DATA_W-1:0] psNext;
  logic [DATA_W-1:0] tbrReg;
  logic [DATA_W-1:0] rpReg;
  logic [DATA_W-1:0] uspReg;
  logic [DATA_W-1:0] sspReg;
  logic [DATA_W-1:0] mdhReg;
  logic [DATA_W-1:0] mdlReg;
  logic [DATA_W-1:0] mulAReg;
  logic [DATA_W-1:0] mulBReg;
  logic              mulShortReg;
  logic [2:0]        mulCntReg;
  logic [2:0]        entryCntReg;
  logic [4:0]        entryLvlReg;
  logic [7:0]        entryVecReg;
  cscr_pkg::cscr_state_type stateReg;

  ////////////////////////////////////////////////////////////////////////
  // Decode of status fields and bus strobes
  wire logic        stackSel = psReg[`CSCR_S_BIT];
  wire logic        intEn    = psReg[`CSCR_I_BIT];
  wire logic        traceEn  = psReg[`CSCR_T_BIT];
  wire logic [4:0]  ilmVal   = psReg[`CSCR_ILM_MSB:`CSCR_ILM_LSB];
  wire logic        apbSetup = psel & ~penable;
  wire logic        apbWr    = psel & penable & pwrite & pready;
  wire logic        gprHit   = (paddr[11:6] == `CSCR_GPR_PAGE);
  wire logic [3:0]  apbIdx   = paddr[5:2];
  wire logic        hitPs    = (paddr == `CSCR_OFF_PS);
  wire logic        hitPc    = (paddr == `CSCR_OFF_PC);
  wire logic        hitTbr   = (paddr == `CSCR_OFF_TBR);
  wire logic        hitRp    = (paddr == `CSCR_OFF_RP);
  wire logic        hitUsp   = (paddr == `CSCR_OFF_USP);
  wire logic        hitSsp   = (paddr == `CSCR_OFF_SSP);
  wire logic        hitMdh   = (paddr == `CSCR_OFF_MDH);
  wire logic        hitMdl   = (paddr == `CSCR_OFF_MDL);
  wire logic        hitMulA  = (paddr == `CSCR_OFF_MULA);
  wire logic        hitMulB  = (paddr == `CSCR_OFF_MULB);
  wire logic        hitMulC  = (paddr == `CSCR_OFF_MULCTL);
  wire logic        mapped   = gprHit | hitPs | hitPc | hitTbr | hitRp | hitUsp
                             | hitSsp | hitMdh | hitMdl | hitMulA | hitMulB | hitMulC;
  wire logic [DATA_W-1:0] stackView = stackSel ? uspReg : sspReg;

  wire logic [DATA_W-1:0] apbGprView =
    (apbIdx == 4'hF) ? stackView : gprMem[apbIdx];
  wire logic [DATA_W-1:0] coreGprView =
    (gprRdIdx == 4'hF) ? stackView : gprMem[gprRdIdx];

  wire logic [DATA_W-1:0] mulCtlView =
    {{(DATA_W-2){1'b0}}, mulShortReg, mulBusy};
  wire logic [DATA_W-1:0] rdMux =
    gprHit  ? apbGprView :
    hitPs   ? psReg      :
    hitPc   ? pcReg      :
    hitTbr  ? tbrReg     :
    hitRp   ? rpReg      :
    hitUsp  ? uspReg     :
    hitSsp  ? sspReg     :
    hitMdh  ? mdhReg     :
    hitMdl  ? mdlReg     :
    hitMulA ? mulAReg    :
    hitMulB ? mulBReg    :
    hitMulC ? mulCtlView : '0;

  wire logic acceptIrq = (stateReg == cscr_pkg::ST_RUN) & irqReq & intEn
                       & (irqLevel < ilmVal);
  wire logic entryEnd  = (stateReg == cscr_pkg::ST_ENTRY) & (entryCntReg == 3'h1);
  wire logic [DATA_W-1:0] vecAddr = tbrReg + {{(DATA_W-10){1'b0}}, entryVecReg, 2'b00};

  // Multiply start and operand products
  wire logic mulGo = apbWr & hitMulC & pwdata[`CSCR_MUL_GO_BIT] & ~mulBusy;
  wire logic mulSh = pwdata[`CSCR_MUL_SH_BIT];
  wire logic [2*DATA_W-1:0] prodLong =
    $signed(mulAReg) * $signed(mulBReg);
  wire logic [DATA_W-1:0] prodShort =
    DATA_W'($signed(mulAReg[15:0]) * $signed(mulBReg[15:0]));
  wire logic mulEnd = mulBusy & (mulCntReg == 3'h1);

  ////////////////////////////////////////////////////////////////////////
  // APB answer: one setup, one access cycle, no wait states
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready <= apbSetup;
      if (apbSetup) begin
        prdata  <= pwrite ? '0 : rdMux;
        pslverr <= ~mapped;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // R0..R14 hold data only; left without reset on purpose
  // low registers undefined
  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      if (apbWr && gprHit && apbIdx != 4'hF)
        gprMem[apbIdx] <= pwdata;
      if (gprWrEn && gprWrIdx != 4'hF)
        gprMem[gprWrIdx] <= gprWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      gprRdData <= '0;
    else if (clkEn)
      gprRdData <= coreGprView;
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack pointers; core port wins over the bus in the same cycle
  wire logic apbR15 = apbWr & gprHit & (apbIdx == 4'hF);
  wire logic coreR15 = gprWrEn & (gprWrIdx == 4'hF);

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      sspReg <= `CSCR_SSP_RST;
    else if (clkEn) begin
      if ((apbWr && hitSsp) || (apbR15 && !stackSel))
        sspReg <= pwdata;
      if (coreR15 && !stackSel)
        sspReg <= gprWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      if ((apbWr && hitUsp) || (apbR15 && stackSel))
        uspReg <= pwdata;
      if (coreR15 && stackSel)
        uspReg <= gprWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // vector base reset
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      tbrReg <= `CSCR_TBR_RST;
    else if (clkEn && apbWr && hitTbr)
      tbrReg <= pwdata;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      rpReg <= '0;
    else if (clkEn) begin
      if (apbWr && hitRp)
        rpReg <= pwdata;
      if (callInstr && !entryEnd)
        rpReg <= pcReg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // PC priority: entry, interrupt exit, call, subroutine exit, advance
  // executing address
  always_ff @(posedge core_clk) begin
    if (sys_rst)
      pcReg <= '0;
    else if (clkEn) begin
      if (entryEnd)
        pcReg <= vecAddr;
      else if (retiInstr)
        pcReg <= retiPc;
      else if (callInstr)
        pcReg <= callTarget;
      else if (retInstr)
        pcReg <= rpReg;
      else if (instrDone)
        pcReg <= nextPc;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status word next value; reserved bits masked on every path
  always_comb begin
    psNext = psReg;
    if (apbWr && hitPs)
      psNext = pwdata;
    if (psWrEn)
      psNext = psWrData;
    if (divSetup) begin
      psNext[`CSCR_D1_BIT] = divFlags[1];
      psNext[`CSCR_D0_BIT] = divFlags[0];
    end
    if (retiInstr)
      psNext = retiPs;
    if (entryEnd) begin
      psNext[`CSCR_ILM_MSB:`CSCR_ILM_LSB] = entryLvlReg;
      psNext[`CSCR_S_BIT] = 1'b0;
      psNext[`CSCR_T_BIT] = 1'b0;
    end
    psNext = psNext & `CSCR_PS_MASK;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      psReg <= `CSCR_PS_RST;
    else if (clkEn)
      psReg <= psNext;
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt entry: state, countdown, captured context
  // six cycle entry
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stateReg    <= cscr_pkg::ST_RUN;
      entryCntReg <= '0;
      entryLvlReg <= `CSCR_ILM_RST;
      entryVecReg <= '0;
      eitEntry    <= 1'b0;
      eitSavedPc  <= '0;
      eitSavedPs  <= '0;
    end else if (clkEn) begin
      eitEntry <= 1'b0;
      case (stateReg)
        cscr_pkg::ST_RUN: begin
          if (acceptIrq) begin
            stateReg    <= cscr_pkg::ST_ENTRY;
            entryCntReg <= `CSCR_ENTRY_CYC - 3'h1;
            entryLvlReg <= irqLevel;
            entryVecReg <= irqVector;
            eitSavedPc  <= pcReg;
            eitSavedPs  <= psReg;
          end
        end
        cscr_pkg::ST_ENTRY: begin
          entryCntReg <= entryCntReg - 3'h1;
          if (entryEnd) begin
            stateReg <= cscr_pkg::ST_RUN;
            eitEntry <= 1'b1;
          end
        end
        default: stateReg <= cscr_pkg::ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst)
      traceTrap <= 1'b0;
    else if (clkEn)
      traceTrap <= instrDone & traceEn;
  end

  ////////////////////////////////////////////////////////////////////////
  // Multiplier: result lands when the count expires
  // five or three cycles
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mulBusy     <= 1'b0;
      mulCntReg   <= '0;
      mulShortReg <= 1'b0;
    end else if (clkEn) begin
      if (mulGo) begin
        mulBusy     <= 1'b1;
        mulShortReg <= mulSh;
        mulCntReg   <= mulSh ? `CSCR_MUL16_CYC : `CSCR_MUL32_CYC;
      end else if (mulBusy) begin
        mulCntReg <= mulCntReg - 3'h1;
        if (mulEnd)
          mulBusy <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      if (apbWr && hitMulA && !mulBusy)
        mulAReg <= pwdata;
      if (apbWr && hitMulB && !mulBusy)
        mulBReg <= pwdata;
      if (apbWr && hitMdh)
        mdhReg <= pwdata;
      if (apbWr && hitMdl)
        mdlReg <= pwdata;
      if (mulEnd && mulShortReg)
        mdlReg <= prodShort;
      else if (mulEnd) begin
        mdhReg <= prodLong[2*DATA_W-1:DATA_W];
        mdlReg <= prodLong[DATA_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign pcOut = pcReg;
  assign psOut = psReg;

  ////////////////////////////////////////////////////////////////////////
  // Checks assume clkEn stays high across the watched window
  chk_ssp_after_reset: assert property (
    @(posedge core_clk) sys_rst |=> (sspReg == '0))
    else $error("system stack not zero after reset");

  chk_ps_reserved_zero: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (psOut & ~`CSCR_PS_MASK) == '0)
    else $error("reserved status bits set");

  chk_status_reset: assert property (
    @(posedge core_clk) sys_rst |=> (psOut[20:16] == 5'h0F)
      && (psOut[6:4] == 3'h0) && !psOut[8])
    else $error("status reset value wrong");

  chk_tbr_reset_val: assert property (
    @(posedge core_clk) sys_rst |=> (tbrReg == 32'h000F_FC00))
    else $error("vector base reset value wrong");

  chk_call_saves_pc: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clkEn && callInstr && !entryEnd) |=> (rpReg == $past(pcOut)))
    else $error("call did not save PC");

  chk_ret_loads_pc: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clkEn && retInstr && !callInstr && !retiInstr && !entryEnd)
      |=> (pcOut == $past(rpReg)))
    else $error("exit did not restore PC");

  chk_trace_trap_gate: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clkEn && instrDone) |=> (traceTrap == $past(psOut[8])))
    else $error("trace trap does not follow enable");

  chk_mul_long_time: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clkEn && mulGo && !mulSh) |=> mulBusy [*5] ##1 !mulBusy)
    else $error("long multiply not five cycles");

  chk_mul_short_time: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clkEn && mulGo && mulSh) |=> mulBusy [*3] ##1 !mulBusy)
    else $error("short multiply not three cycles");

  chk_entry_six_cycles: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clkEn && acceptIrq) |-> !eitEntry [*6] ##1 eitEntry)
    else $error("interrupt entry not six cycles");

  chk_interrupt_exit_instr_keeps_usp: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (retiInstr && !apbWr && !gprWrEn) |=> $stable(uspReg))
    else $error("interrupt exit changed user stack");

  chk_div_preupdate: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (clkEn && divSetup && !retiInstr) |=> (psOut[10:9] == $past(divFlags)))
    else $error("divide flags not pre-updated");

endmodule

//--- cscr_params.svh
// Constants of the core status and register block: offsets, fields,
// reset values and cycle counts. Assumes a 32-bit APB data path.
`ifndef CSCR_PARAMS_SVH
`define CSCR_PARAMS_SVH
////////////////////////////////////////////////////////////////////////
`define CSCR_OFF_PS      12'h000
`define CSCR_OFF_PC      12'h004
`define CSCR_OFF_TBR     12'h008
`define CSCR_OFF_RP      12'h00C
`define CSCR_OFF_USP     12'h010
`define CSCR_OFF_SSP     12'h014
`define CSCR_OFF_MDH     12'h018
`define CSCR_OFF_MDL     12'h01C
`define CSCR_OFF_MULA    12'h020
`define CSCR_OFF_MULB    12'h024
`define CSCR_OFF_MULCTL  12'h028
`define CSCR_GPR_PAGE    6'h01
////////////////////////////////////////////////////////////////////////
`define CSCR_PS_MASK     32'h001F_077F
`define CSCR_ILM_LSB     16
`define CSCR_ILM_MSB     20
`define CSCR_D1_BIT      10
`define CSCR_D0_BIT      9
`define CSCR_T_BIT       8
`define CSCR_SV_BIT      6
`define CSCR_S_BIT       5
`define CSCR_I_BIT       4
`define CSCR_MUL_GO_BIT  0
`define CSCR_MUL_SH_BIT  1
////////////////////////////////////////////////////////////////////////
`define CSCR_PS_RST      32'h000F_0000
`define CSCR_ILM_RST     5'h0F
`define CSCR_TBR_RST     32'h000F_FC00
`define CSCR_SSP_RST     32'h0000_0000
////////////////////////////////////////////////////////////////////////
`define CSCR_MUL32_CYC   3'h5
`define CSCR_MUL16_CYC   3'h3
`define CSCR_ENTRY_CYC   3'h6
`endif

//--- cscr_pkg.sv
// Types shared by the core status and register block.
// Assumes nothing of its surroundings.
package cscr_pkg;
  typedef enum logic [0:0] {
    ST_RUN,
    ST_ENTRY
  } cscr_state_type;
endpackage

//--- testbench.sv
// Self-checking bench for the core status and register block.
// Assumes an APB slave that answers with pready and core events given as pulses.
`timescale 1ns/1ps
`include "cscr_params.svh"

module testbench;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clkEn = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = '0, gprWrData = '0, nextPc = '0, callTarget = '0;
  logic [31:0] retiPc = '0, retiPs = '0, psWrData = '0, rdVal;
  logic [3:0]  gprRdIdx = 4'h0, gprWrIdx = 4'h0;
  logic        gprWrEn = 0, instrDone = 0, callInstr = 0, retInstr = 0, retiInstr = 0;
  logic        divSetup = 0, psWrEn = 0, irqReq = 0, rdErr;
  logic [1:0]  divFlags = 2'h0;
  logic [4:0]  irqLevel = 5'h00;
  logic [7:0]  irqVector = 8'h00;
  logic [31:0] prdata, gprRdData, pcOut, psOut, eitSavedPc, eitSavedPs;
  logic        pready, pslverr, eitEntry, traceTrap, mulBusy;
  int          failures = 0, checks = 0, cycles = 0;

  cscr_core_regs cscr_core_regs_inst (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gprRdIdx(gprRdIdx),
    .gprRdData(gprRdData), .gprWrEn(gprWrEn), .gprWrIdx(gprWrIdx),
    .gprWrData(gprWrData), .instrDone(instrDone), .nextPc(nextPc),
    .callInstr(callInstr), .callTarget(callTarget), .retInstr(retInstr),
    .retiInstr(retiInstr), .retiPc(retiPc), .retiPs(retiPs), .divSetup(divSetup),
    .divFlags(divFlags), .psWrEn(psWrEn), .psWrData(psWrData), .irqReq(irqReq),
    .irqLevel(irqLevel), .irqVector(irqVector), .pcOut(pcOut), .psOut(psOut),
    .eitEntry(eitEntry), .eitSavedPc(eitSavedPc), .eitSavedPs(eitSavedPs),
    .traceTrap(traceTrap), .mulBusy(mulBusy));

  always #20 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // A hang counts as a mismatch so the run still reaches the verdict
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      end_sim;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until pready is sampled high; data taken at that edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Ended by pready high; only the bench timeout ends a hung wait
    while (pready !== 1'b1)
      @(posedge core_clk);
    rdVal = prdata;
    rdErr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task psw(input logic [31:0] d);
    @(posedge core_clk); psWrEn <= 1'b1; psWrData <= d;
    @(posedge core_clk); psWrEn <= 1'b0;
  endtask

  task gprRd(input logic [3:0] i);
    @(posedge core_clk); gprRdIdx <= i;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Index of the first sampled cycle with eitEntry high, 0 if none
  task waitEntry(output int k);
    k = 0;
    for (int c = 1; c <= 12; c++) begin
      @(negedge core_clk);
      if (eitEntry === 1'b1 && k == 0) k = c;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task test_reset;
    apb(0, `CSCR_OFF_PS, 0); chk(rdVal, 32'h000F_0000);
    chk(psOut, 32'h000F_0000);
    apb(0, `CSCR_OFF_TBR, 0); chk(rdVal, 32'h000F_FC00);
    apb(0, `CSCR_OFF_SSP, 0); chk(rdVal, 32'h0000_0000);
    apb(0, 12'h07C, 0); chk(rdVal, 32'h0000_0000);
    apb(1, `CSCR_OFF_PC, 32'hDEAD_BEEF); apb(0, `CSCR_OFF_PC, 0); chk(rdVal, 0);
    apb(0, 12'h030, 0); chk({31'h0, rdErr}, 1);
    chk(rdVal, 0);
    apb(1, `CSCR_OFF_PS, 32'hFFFF_FFFF); apb(0, `CSCR_OFF_PS, 0);
    chk(rdVal, 32'h001F_077F);
    apb(1, `CSCR_OFF_PS, 32'h000F_0000);
    $display("test_reset done");
  endtask

  task test_stack;
    apb(1, `CSCR_OFF_SSP, 32'h0000_1000); apb(1, `CSCR_OFF_USP, 32'h0000_2000);
    gprRd(4'hF); chk(gprRdData, 32'h0000_1000);
    psw(32'h000F_0020); gprRd(4'hF); chk(gprRdData, 32'h0000_2000);
    apb(0, 12'h07C, 0); chk(rdVal, 32'h0000_2000);
    @(posedge core_clk); gprWrEn <= 1; gprWrIdx <= 4'hD; gprWrData <= 32'h0000_5A5A;
    @(posedge core_clk); gprWrEn <= 0;
    apb(0, 12'h074, 0); chk(rdVal, 32'h0000_5A5A);
    psw(32'h000F_0000);
    $display("test_stack done");
  endtask

  task test_callret;
    @(posedge core_clk); instrDone <= 1; nextPc <= 32'h0000_0100;
    @(posedge core_clk); instrDone <= 0; callInstr <= 1; callTarget <= 32'h0000_0800;
    @(posedge core_clk); callInstr <= 0;
    @(negedge core_clk); chk(pcOut, 32'h0000_0800);
    apb(0, `CSCR_OFF_RP, 0); chk(rdVal, 32'h0000_0100);
    @(posedge core_clk); retInstr <= 1;
    @(posedge core_clk); retInstr <= 0;
    @(negedge core_clk); chk(pcOut, 32'h0000_0100);
    // Enable low must freeze the counter against a retire pulse
    @(posedge core_clk); clkEn <= 0; instrDone <= 1; nextPc <= 32'h0000_0200;
    @(posedge core_clk); clkEn <= 1; instrDone <= 0;
    @(negedge core_clk); chk(pcOut, 32'h0000_0100);
    $display("test_callret done");
  endtask

  task test_trace;
    int n;
    for (int t = 0; t < 2; t++) begin
      psw(32'h000F_0000 | (t << 8));
      @(posedge core_clk); instrDone <= 1; nextPc <= 32'h0000_0104;
      @(posedge core_clk); instrDone <= 0;
      n = 0;
      repeat (4) @(negedge core_clk) if (traceTrap === 1'b1) n++;
      chk(32'(n), 32'(t));
    end
    psw(32'h000F_0000);
    $display("test_trace done");
  endtask

  task mulCase(input logic [31:0] a, b, ctl, cyc, hi, lo);
    int n;
    apb(1, `CSCR_OFF_MULA, a); apb(1, `CSCR_OFF_MULB, b); apb(1, `CSCR_OFF_MULCTL, ctl);
    n = 0;
    repeat (10) @(negedge core_clk) if (mulBusy === 1'b1) n++;
    chk(32'(n), cyc);
    apb(0, `CSCR_OFF_MDL, 0); chk(rdVal, lo);
    if (ctl[1] == 1'b0) begin
      apb(0, `CSCR_OFF_MDH, 0); chk(rdVal, hi);
    end
  endtask

  task test_div;
    for (int f = 0; f < 4; f++) begin
      @(posedge core_clk); divSetup <= 1; divFlags <= 2'(f);
      @(posedge core_clk); divSetup <= 0;
      @(negedge core_clk); chk(32'(psOut[10:9]), 32'(f));
    end
    $display("test_div done");
  endtask

  task test_irq;
    int k;
    apb(1, `CSCR_OFF_USP, 32'h0000_3000);
    psw(32'h000F_0010);
    @(posedge core_clk); irqReq <= 1; irqLevel <= 5'h03; irqVector <= 8'h10;
    @(posedge core_clk); irqReq <= 0;
    waitEntry(k); chk(32'(k), 6);
    chk(pcOut, 32'h000F_FC40); chk(32'(psOut[20:16]), 3);
    chk(eitSavedPs, 32'h000F_0010); chk(eitSavedPc, 32'h0000_0104);
    // Level equal to the mask must stay pending
    @(posedge core_clk); irqReq <= 1;
    waitEntry(k); chk(32'(k), 0);
    @(posedge core_clk); irqReq <= 0; retiInstr <= 1;
    retiPc <= 32'h0000_0104; retiPs <= 32'h000F_0020;
    @(posedge core_clk); retiInstr <= 0;
    @(negedge core_clk); chk(pcOut, 32'h0000_0104);
    chk(psOut, 32'h000F_0020);
    apb(0, `CSCR_OFF_USP, 0); chk(rdVal, 32'h0000_3000);
    @(posedge core_clk); irqReq <= 1;
    repeat (3) @(posedge core_clk);
    psw(32'h000F_0030);
    waitEntry(k); chk(32'(k), 7); chk(eitSavedPs, 32'h000F_0030);
    @(posedge core_clk); irqReq <= 0;
    $display("test_irq done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    test_reset;
    test_stack;
    test_callret;
    test_trace;
    mulCase(32'h0001_0000, 32'h0002_0003, 32'h1, 5, 32'h2, 32'h0003_0000);
    mulCase(32'h0000_FFFE, 32'h0000_0003, 32'h3, 3, 32'h0, 32'hFFFF_FFFA);
    $display("test_mul done");
    test_div;
    test_irq;
    end_sim;
  end
endmodule
